// *** peripheral_interrupt_flags_bench.sv ***
// Purpose: Self-checking bench for the peripheral flag block
// Assumes: APB master waits on pready; reads checked from a queue
// Notes: Random mix drives sources, enables and control bits
`timescale 1ns/100ps
module peripheral_interrupt_flags_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] pstrb, cell_go, lci, ack_dly;
  logic [2:0] gate_go, tg;
  logic [5:0] timer_req;
  logic osc, csw, thr, cdn, ack, req, ack_on, irq, e;
  logic [14:0] vector_addr;
  logic [31:0] exp_q[$];
  int mismatches = 0;
  int checks = 0;
  integer seed = 32'h9bdb0035;
  pif_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_fail_req(osc), .clk_switch_req(csw), .conv_threshold_req(thr),
    .conv_done_req(cdn), .timer_req(timer_req), .logic_cell_int(lci),
    .timer_gate(tg), .core_int_ack(ack), .core_int_req(req),
    .vector_addr(vector_addr), .irq(irq));
  pif_partner u_core (.pclk(pclk), .presetn(presetn), .cell_go(cell_go),
    .gate_go(gate_go), .core_int_req(req), .ack_on(ack_on),
    .ack_dly(ack_dly), .logic_cell_int(lci), .timer_gate(tg),
    .core_int_ack(ack));
  // ==========================================================
  // Checking and bus tasks
  task automatic check(input logic [31:0] got, input logic [31:0] ex);
    checks++;
    if (got !== ex) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, ex);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ex);
    exp_q.push_back(ex);
    apb(1'b0, a, 32'h0, 4'hf);
  endtask
  task automatic pulse(input logic [3:0] c, input logic [2:0] g);
    cell_go <= c;
    gate_go <= g;
    repeat (2) @(posedge pclk);
    cell_go <= 4'h0;
    gate_go <= 3'h0;
    repeat (4) @(posedge pclk);
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      check({31'h0, pslverr}, {31'h0, paddr > 8'h18});
      if (!pwrite && exp_q.size() > 0) check(prdata, exp_q.pop_front());
    end
  end
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    mismatches++;
    give_verdict();
  end
  // ==========================================================
  // Main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    {osc, csw, thr, cdn, timer_req, cell_go, gate_go, ack_on} = '0;
    ack_dly = 4'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(pif_pkg::OFF_EN1, 32'h0);
    rd(pif_pkg::OFF_EN4, 32'h0);
    rd(pif_pkg::OFF_REQ5, 32'h0);
    check({17'h0, vector_addr}, {17'h0, pif_pkg::RESET_VECTOR});
    wr(pif_pkg::OFF_EN1, 32'hffffffff);
    rd(pif_pkg::OFF_EN1, 32'hc3);
    wr(pif_pkg::OFF_EN4, 32'hffffffff);
    rd(pif_pkg::OFF_EN4, 32'h3f);
    pulse(4'hf, 3'h7);
    rd(pif_pkg::OFF_REQ5, 32'hf7);
    // Source enabled and global on, peripheral gate off
    osc <= 1'b1;
    wr(pif_pkg::OFF_INTCTL, 32'h80);
    check({31'h0, req}, 32'h0);
    // Event seen at the very edge of a clearing write
    cell_go <= 4'h2;
    fork
      wr(pif_pkg::OFF_REQ5, 32'h0);
      begin
        @(posedge pclk);
        cell_go <= 4'h0;
      end
    join
    rd(pif_pkg::OFF_REQ5, 32'h20);
    wr(pif_pkg::OFF_REQ5, 32'h0);
    rd(pif_pkg::OFF_REQ5, 32'h0);
    for (int i = 0; i < 24; i++) begin
      r = $random(seed);
      {osc, csw, thr, cdn, timer_req} <= r[9:0];
      wr(pif_pkg::OFF_EN1, {24'h0, r[17:10]});
      wr(pif_pkg::OFF_EN4, {24'h0, r[25:18]});
      wr(pif_pkg::OFF_INTCTL, {24'h0, r[27:26], 6'h0});
      e = |({r[9:8], 4'h0, r[7:6]} & r[17:10] & 8'hc3);
      e = (e | |(r[5:0] & r[23:18])) & r[27] & r[26];
      @(negedge pclk);
      check({31'h0, req}, {31'h0, e});
      // Back on the rising edge before the next bus request
      @(posedge pclk);
    end
    wr(pif_pkg::OFF_EN1, 32'h0);
    wr(pif_pkg::OFF_EN4, 32'h0);
    apb(1'b1, pif_pkg::OFF_EN4, 32'hff, 4'h0);
    rd(pif_pkg::OFF_EN4, 32'h0);
    rd(8'h1c, 32'h0);
    wr(pif_pkg::OFF_PIE5, 32'h10);
    wr(pif_pkg::OFF_INTCTL, 32'hc0);
    pulse(4'h1, 3'h0);
    check({31'h0, req}, 32'h1);
    ack_dly <= 4'h3;
    ack_on <= 1'b1;
    repeat (8) @(posedge pclk);
    ack_on <= 1'b0;
    repeat (2) @(posedge pclk);
    check({17'h0, vector_addr}, {17'h0, pif_pkg::INT_VECTOR});
    check({31'h0, irq}, 32'h0);
    wr(pif_pkg::OFF_IRQ_MASK, 32'h1);
    check({31'h0, irq}, 32'h1);
    // Clear both bits, then re-enable the flagged PIE5 source so the stale-enable bit comes back
    wr(pif_pkg::OFF_IRQ_STAT, 32'h3);
    check({31'h0, irq}, 32'h0);
    rd(pif_pkg::OFF_IRQ_STAT, 32'h0);
    wr(pif_pkg::OFF_PIE5, 32'h0);
    wr(pif_pkg::OFF_PIE5, 32'h10);
    rd(pif_pkg::OFF_IRQ_STAT, 32'h2);
    wr(pif_pkg::OFF_REQ5, 32'h0);
    check({31'h0, req}, 32'h0);
    // Mid-run reset brings every register back
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check({17'h0, vector_addr}, {17'h0, pif_pkg::RESET_VECTOR});
    rd(pif_pkg::OFF_PIE5, 32'h0);
    rd(pif_pkg::OFF_INTCTL, 32'h0);
    give_verdict();
  end
endmodule

// *** pif_partner.sv ***
// Purpose: Core and event-source model facing the flag block
// Assumes: Bench commands events one cycle ahead on pclk
// Notes: Ack delay can be zero (prompt) or longer (slow core)
`timescale 1ns/100ps
module pif_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] cell_go,
  input wire logic [2:0] gate_go,
  input wire logic core_int_req,
  input wire logic ack_on,
  input wire logic [3:0] ack_dly,
  output logic [3:0] logic_cell_int,
  output logic [2:0] timer_gate,
  output logic core_int_ack
);
  logic [3:0] wait_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      logic_cell_int <= 4'h0;
      timer_gate <= 3'h0;
    end else begin
      logic_cell_int <= cell_go;
      timer_gate <= gate_go;
    end
  end
  // Slow core waits before it accepts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 4'h0;
      core_int_ack <= 1'b0;
    end else begin
      core_int_ack <= 1'b0;
      if (!(ack_on && core_int_req)) begin
        wait_cnt <= 4'h0;
      end else if (wait_cnt == ack_dly) begin
        core_int_ack <= 1'b1;
        wait_cnt <= 4'h0;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule

// *** pif_pkg.sv ***
// Purpose: Constants for the peripheral interrupt flag block
// Assumes: APB word-aligned register map, 8-bit registers in low byte
// Notes: Unused upper bits of every register read as zero
package pif_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_EN1 = 8'h00;
  localparam logic [7:0] OFF_EN4 = 8'h04;
  localparam logic [7:0] OFF_REQ5 = 8'h08;
  localparam logic [7:0] OFF_PIE5 = 8'h0c;
  localparam logic [7:0] OFF_INTCTL = 8'h10;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
  // ==========================================================
  // Implemented-bit masks
  localparam logic [7:0] EN1_MASK = 8'hc3;
  localparam logic [7:0] EN4_MASK = 8'h3f;
  localparam logic [7:0] REQ5_MASK = 8'hf7;
  localparam logic [7:0] INTCTL_MASK = 8'hc0;
  localparam logic [1:0] IRQ_MASK_BITS = 2'h3;
  // ==========================================================
  // Field positions
  localparam int OSC_FAIL_BIT = 7;
  localparam int CLK_SWITCH_BIT = 6;
  localparam int CONV_THRESH_BIT = 1;
  localparam int CONV_DONE_BIT = 0;
  localparam int GLOBAL_EN_BIT = 7;
  localparam int PERIPH_EN_BIT = 6;
  localparam int CELL_FLAG_LSB = 4;
  localparam int ST_ACCEPT_BIT = 0;
  localparam int ST_STALE_BIT = 1;
  // ==========================================================
  // Reset values and vectors
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [14:0] RESET_VECTOR = 15'h0000;
  localparam logic [14:0] INT_VECTOR = 15'h0004;
endpackage

// *** pif_top.sv ***
// Purpose: Peripheral interrupt enables, request flags, core request
// Assumes: All event inputs come from logic on pclk
// Notes: APB slave answers with zero wait states
// Summary of operation
// - On accepted interrupt load vector 0004h; reset vector is 0000h.
// - First enable bit 7 gates oscillator-fail interrupt.
// - First enable bit 6 gates clock-switch-complete interrupt.
// - First enable bit 0 gates converter done interrupt.
// - First enable bits 5..2 ignore writes and read zero.
// - Timer enable register holds six enables, bits 7..6 read zero.
// - Request bits 7..4 set by logic cells 4..1, held until cleared.
// - Flags set regardless of enable and global enable bits.
// - Peripheral interrupts reach core only with peripheral enable set.
//
// Decided for this implementation: the placing of the registers and the APB slave port.
`timescale 1ns/100ps
module pif_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_fail_req,
  input wire logic clk_switch_req,
  input wire logic conv_threshold_req,
  input wire logic conv_done_req,
  input wire logic [5:0] timer_req,
  input wire logic [3:0] logic_cell_int,
  input wire logic [2:0] timer_gate,
  input wire logic core_int_ack,
  output logic core_int_req,
  output logic [14:0] vector_addr,
  output logic irq
);
  // ==========================================================
  // Register state
  logic [7:0] periph_int_enable_1;
  logic [7:0] periph_int_enable_4;
  logic [7:0] periph_int_request_5;
  logic [7:0] periph_int_enable_5;
  logic [7:0] int_control_reg;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [2:0] gate_prev;
  logic global_int_en;
  logic periph_int_global_en;

  // ==========================================================
  // APB decode
  logic wr_en;
  logic setup;
  logic mapped;
  logic [7:0] wbyte;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && pstrb[0];
  assign wbyte = pwdata[7:0];
  assign pready = 1'b1;

  always_comb begin
    case (paddr)
      pif_pkg::OFF_EN1, pif_pkg::OFF_EN4, pif_pkg::OFF_REQ5,
      pif_pkg::OFF_PIE5, pif_pkg::OFF_INTCTL, pif_pkg::OFF_IRQ_STAT,
      pif_pkg::OFF_IRQ_MASK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Unmapped addresses error in the access phase only
  assign pslverr = psel && penable && !mapped;

  // ==========================================================
  // Enable registers
  // all bits clear at reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_int_enable_1 <= pif_pkg::REG_RESET;
    // bit 7, bit 6, bit 1, bit 0 writable
    end else if (wr_en && paddr == pif_pkg::OFF_EN1) begin
      periph_int_enable_1 <= wbyte & pif_pkg::EN1_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_int_enable_4 <= pif_pkg::REG_RESET;
    end else if (wr_en && paddr == pif_pkg::OFF_EN4) begin
      periph_int_enable_4 <= wbyte & pif_pkg::EN4_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_int_enable_5 <= pif_pkg::REG_RESET;
    end else if (wr_en && paddr == pif_pkg::OFF_PIE5) begin
      periph_int_enable_5 <= wbyte & pif_pkg::REQ5_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_control_reg <= pif_pkg::REG_RESET;
    end else if (wr_en && paddr == pif_pkg::OFF_INTCTL) begin
      int_control_reg <= wbyte & pif_pkg::INTCTL_MASK;
    end
  end

  assign global_int_en = int_control_reg[pif_pkg::GLOBAL_EN_BIT];
  assign periph_int_global_en = int_control_reg[pif_pkg::PERIPH_EN_BIT];

  // ==========================================================
  // Request flags
  logic [7:0] flag_set;
  logic [7:0] next_req5;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_prev <= 3'h0;
    end else begin
      gate_prev <= timer_gate;
    end
  end

  // gate closing is a falling edge, bit 3 stays zero
  assign flag_set = {logic_cell_int, 1'b0, gate_prev & ~timer_gate};

  // set ignores every enable; set wins over a clear
  always_comb begin
    next_req5 = periph_int_request_5;
    if (wr_en && paddr == pif_pkg::OFF_REQ5) begin
      next_req5 = wbyte;
    end
    next_req5 = (next_req5 | flag_set) & pif_pkg::REQ5_MASK;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_int_request_5 <= pif_pkg::REG_RESET;
    end else begin
      periph_int_request_5 <= next_req5;
    end
  end

  // ==========================================================
  // Core request and vector
  logic [3:0] misc_src;
  logic [7:0] en1_src;
  logic any_pending;

  assign misc_src = {osc_fail_req, clk_switch_req,
                     conv_threshold_req, conv_done_req};
  assign en1_src = {misc_src[3:2], 4'h0, misc_src[1:0]};
  assign any_pending =
    |(periph_int_enable_1 & en1_src) ||
    |(periph_int_enable_4 & {2'h0, timer_req}) ||
    |(periph_int_enable_5 & periph_int_request_5);

  // flag, enable and both global enables
  assign core_int_req = any_pending && periph_int_global_en &&
                        global_int_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_addr <= pif_pkg::RESET_VECTOR;
    end else if (core_int_ack) begin
      vector_addr <= pif_pkg::INT_VECTOR;
    end
  end

  // ==========================================================
  // Status, mask and interrupt line
  logic stale_en;
  logic [1:0] st_set;

  // Enabling a source whose flag is already up hints at misuse
  assign stale_en = wr_en && (
    (paddr == pif_pkg::OFF_PIE5 &&
      |(wbyte & ~periph_int_enable_5 & periph_int_request_5)) ||
    (paddr == pif_pkg::OFF_EN1 &&
      |(wbyte & ~periph_int_enable_1 & en1_src & pif_pkg::EN1_MASK)));
  assign st_set = {stale_en, core_int_ack};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= 2'h0;
    end else if (wr_en && paddr == pif_pkg::OFF_IRQ_STAT) begin
      irq_status <= (irq_status & ~wbyte[1:0]) | st_set;
    end else begin
      irq_status <= irq_status | st_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= 2'h0;
    end else if (wr_en && paddr == pif_pkg::OFF_IRQ_MASK) begin
      irq_mask <= wbyte[1:0] & pif_pkg::IRQ_MASK_BITS;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ==========================================================
  // Read data, captured in the setup phase
  logic [7:0] rd_byte;

  always_comb begin
    case (paddr)
      pif_pkg::OFF_EN1: rd_byte = periph_int_enable_1;
      pif_pkg::OFF_EN4: rd_byte = periph_int_enable_4;
      pif_pkg::OFF_REQ5: rd_byte = periph_int_request_5;
      pif_pkg::OFF_PIE5: rd_byte = periph_int_enable_5;
      pif_pkg::OFF_INTCTL: rd_byte = int_control_reg;
      pif_pkg::OFF_IRQ_STAT: rd_byte = {6'h00, irq_status};
      pif_pkg::OFF_IRQ_MASK: rd_byte = {6'h00, irq_mask};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  // ==========================================================
  // Checks
  sequence en1_wr;
    wr_en && paddr == pif_pkg::OFF_EN1;
  endsequence

  a_vector_on_ack: assert property (
    @(posedge pclk) disable iff (!presetn)
    core_int_ack |=> vector_addr == 15'h0004)
    else $error("vector not loaded on accept");

  a_osc_fail_en: assert property (
    @(posedge pclk) disable iff (!presetn)
    en1_wr |=> periph_int_enable_1[7] == $past(pwdata[7]))
    else $error("oscillator-fail enable wrong");

  a_clk_switch_en: assert property (
    @(posedge pclk) disable iff (!presetn)
    en1_wr |=> periph_int_enable_1[6] == $past(pwdata[6]))
    else $error("clock-switch enable wrong");

  a_thresh_en_bit: assert property (
    @(posedge pclk) disable iff (!presetn)
    en1_wr |=> periph_int_enable_1[1] == $past(pwdata[1]))
    else $error("threshold enable wrong");

  a_conv_done_en: assert property (
    @(posedge pclk) disable iff (!presetn)
    en1_wr |=> periph_int_enable_1[0] == $past(pwdata[0]))
    else $error("conversion enable wrong");

  a_en1_unimpl_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    en1_wr |=> periph_int_enable_1[5:2] == 4'h0)
    else $error("unimplemented enable bits set");

  a_timer_en_top: assert property (
    @(posedge pclk) disable iff (!presetn)
    periph_int_enable_4[7:6] == 2'h0)
    else $error("timer enable top bits set");

  a_cell_flag_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    |logic_cell_int |=> (periph_int_request_5[7:4] &
      $past(logic_cell_int)) == $past(logic_cell_int))
    else $error("cell flag not set");

  a_flag_set_wins: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == pif_pkg::OFF_REQ5 && |logic_cell_int) |=>
      (periph_int_request_5[7:4] & $past(logic_cell_int)) ==
        $past(logic_cell_int))
    else $error("event lost to a clearing write");

  a_gate_flag_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 (|($past(timer_gate) & ~timer_gate)) |=>
      ((periph_int_request_5[2:0] & $past(timer_gate, 2) &
        ~$past(timer_gate)) ==
        ($past(timer_gate, 2) & ~$past(timer_gate))) &&
      !periph_int_request_5[3])
    else $error("gate flag not set");

  a_periph_gate_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    !periph_int_global_en |-> !core_int_req)
    else $error("request without peripheral enable");

  a_req_from_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    (|(periph_int_enable_5 & periph_int_request_5) &&
      global_int_en && periph_int_global_en) [*2] |-> core_int_req)
    else $error("missing core request");
endmodule
